// *** rtl/ptcc_pkg.sv ***
// Package for the periodic timer capture/compare block
package ptcc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_CTRL1   = 4'h1;
  localparam logic [3:0] ADDR_CAPCLR  = 4'h2;
  localparam logic [3:0] ADDR_CNT_LO  = 4'h3;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h4;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h5;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h6;
  localparam logic [3:0] ADDR_CMPP_LO = 4'h7;
  localparam logic [3:0] ADDR_CMPP_HI = 4'h8;
  localparam logic [3:0] ADDR_CMPB_LO = 4'h9;
  localparam logic [3:0] ADDR_CMPB_HI = 4'ha;

  // Field positions
  localparam int RUN_BIT  = 3;
  localparam int CCLR_BIT = 0;
  localparam int CAPS_BIT = 1;
  localparam int POL_BIT  = 2;
  localparam int OC_BIT   = 3;
  localparam int PF_LSB   = 4;
  localparam int MODE_LSB = 6;
  localparam int TCLR_LSB = 1;
  localparam int VLF_BIT  = 0;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RUN_MASK   = 8'h08;
  localparam logic [7:0] CAPCLR_MSK = 8'h06;

  typedef enum logic [1:0] {
    PTCC_CMP_OUT,
    PTCC_CAPTURE,
    PTCC_PWM,
    PTCC_TIMER
  } ptcc_mode_t;

  // Pin function codes
  localparam logic [1:0] PF_0 = 2'h0;
  localparam logic [1:0] PF_1 = 2'h1;
  localparam logic [1:0] PF_2 = 2'h2;
  localparam logic [1:0] PF_3 = 2'h3;
  localparam logic [1:0] TCLR_NONE = 2'h0;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ptcc_bus_t;
endpackage

// *** rtl/ptcc_timer.sv ***
// Periodic timer with capture, compare match output and PWM
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ptcc_timer #(
  parameter int CNT_W   = 16,
  parameter bit INST0   = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire ptcc_pkg::ptcc_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic              capture_input_pin,
  input  wire logic              external_clock_pin,
  input  wire logic              filtered_data,
  input  wire logic              filter_input_select,
  output logic                   timer_out,
  output logic                   timer_out_en
);
  localparam int HI_W = CNT_W - 8;

  logic [7:0]       ctrl0_ff;
  logic [7:0]       ctrl1_ff;
  logic [1:0]       tclr_ff;
  logic             vlf_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cmpa_ff;
  logic [CNT_W-1:0] cmpp_ff;
  logic [15:0]      cmpb_ff;
  logic             run_d_ff;
  logic             raw_ff;
  logic             out_ff;
  logic             cap_s1_ff;
  logic             cap_s2_ff;
  logic             cap_s3_ff;
  logic             pulse_done_ff;
  logic [7:0]       rdata_ff;
  logic             pin_ff;
  logic             pin_en_ff;

  wire ptcc_pkg::ptcc_mode_t mode = ptcc_pkg::ptcc_mode_t'(ctrl1_ff[ptcc_pkg::MODE_LSB +: 2]);
  wire [1:0] pf      = ctrl1_ff[ptcc_pkg::PF_LSB +: 2];
  wire       oc      = ctrl1_ff[ptcc_pkg::OC_BIT];
  wire       pol     = ctrl1_ff[ptcc_pkg::POL_BIT];
  wire       caps    = ctrl1_ff[ptcc_pkg::CAPS_BIT];
  wire       cclr    = ctrl1_ff[ptcc_pkg::CCLR_BIT];
  wire       run     = ctrl0_ff[ptcc_pkg::RUN_BIT];
  wire       run_up  = run & ~run_d_ff;
  wire       wr      = bus.wr;
  wire [3:0] addr    = bus.addr;
  wire [7:0] wd      = bus.wdata;

  wire cap_src = !caps ? capture_input_pin
               : (INST0 && filter_input_select) ? filtered_data : external_clock_pin;
  wire rise = cap_s2_ff & ~cap_s3_ff;
  wire fall = ~cap_s2_ff & cap_s3_ff;
  wire cap_mode = (mode == ptcc_pkg::PTCC_CAPTURE) && run;
  wire edge_hit = (pf == ptcc_pkg::PF_0) ? rise
                : (pf == ptcc_pkg::PF_1) ? fall
                : (pf == ptcc_pkg::PF_2) ? (rise | fall) : 1'b0;
  wire split = INST0 && (tclr_ff != ptcc_pkg::TCLR_NONE);
  // route capture into A or B
  wire cap_b = cap_mode && edge_hit && split && rise;
  wire cap_a = cap_mode && edge_hit && !(split && rise);
  wire edge_clr = cap_mode && INST0 && ((tclr_ff[0] && rise) || (tclr_ff[1] && fall));

  wire match_a = run && (cnt_ff == cmpa_ff);
  wire match_p = run && (cnt_ff == cmpp_ff) && (cmpp_ff != '0);
  wire at_max  = run && (cnt_ff == {CNT_W{1'b1}});
  wire p_zero  = (cmpp_ff == '0);
  wire use_a   = cclr && (mode == ptcc_pkg::PTCC_CMP_OUT || mode == ptcc_pkg::PTCC_TIMER);
  wire cnt_clr = use_a ? match_a : (match_p || (p_zero && at_max) || edge_clr);
  wire [CNT_W-1:0] nxt_cnt = run_up ? '0 : !run ? cnt_ff : cnt_clr ? '0 : cnt_ff + 1'b1;

  wire pwm_act  = (cnt_ff < cmpa_ff);
  wire nxt_raw_cmp = !match_a ? raw_ff : (pf == ptcc_pkg::PF_1) ? 1'b0
                   : (pf == ptcc_pkg::PF_2) ? 1'b1 : (pf == ptcc_pkg::PF_3) ? ~raw_ff : raw_ff;
  wire nxt_raw_pwm = (pf == ptcc_pkg::PF_0) ? ~oc : (pf == ptcc_pkg::PF_1) ? oc
                   : (pf == ptcc_pkg::PF_2) ? (pwm_act ? oc : ~oc)
                   : ((!pulse_done_ff && run) ? (pwm_act ? oc : ~oc) : ~oc);
  // run rising edge restores initial level, except in PWM mode with pin function PF_0 to PF_2
  wire nxt_raw = (run_up && (mode != ptcc_pkg::PTCC_PWM || pf == ptcc_pkg::PF_3)) ? oc
               : (mode == ptcc_pkg::PTCC_CMP_OUT) ? nxt_raw_cmp
               : (mode == ptcc_pkg::PTCC_PWM) ? nxt_raw_pwm : raw_ff;
  // enable not in timer or capture mode; inversion applies in every mode
  wire out_used = (mode == ptcc_pkg::PTCC_CMP_OUT) || (mode == ptcc_pkg::PTCC_PWM);
  wire nxt_pin  = nxt_raw ^ pol;

  wire [15:0] cnt_x  = 16'(cnt_ff);
  wire [15:0] cmpa_x = 16'(cmpa_ff);
  wire [15:0] cmpp_x = 16'(cmpp_ff);
  wire [7:0] nxt_rdata =
      (addr == ptcc_pkg::ADDR_CTRL0)   ? (ctrl0_ff & ptcc_pkg::RUN_MASK | (ctrl0_ff & 8'hf0)) :
      (addr == ptcc_pkg::ADDR_CTRL1)   ? ctrl1_ff :
      (addr == ptcc_pkg::ADDR_CAPCLR && INST0) ? {5'h00, tclr_ff, vlf_ff} :
      (addr == ptcc_pkg::ADDR_CNT_LO)  ? cnt_x[7:0] :
      (addr == ptcc_pkg::ADDR_CNT_HI)  ? cnt_x[15:8] :
      (addr == ptcc_pkg::ADDR_CMPA_LO) ? cmpa_x[7:0] :
      (addr == ptcc_pkg::ADDR_CMPA_HI) ? cmpa_x[15:8] :
      (addr == ptcc_pkg::ADDR_CMPP_LO) ? cmpp_x[7:0] :
      (addr == ptcc_pkg::ADDR_CMPP_HI) ? cmpp_x[15:8] :
      (addr == ptcc_pkg::ADDR_CMPB_LO && INST0) ? cmpb_ff[7:0] :
      (addr == ptcc_pkg::ADDR_CMPB_HI && INST0) ? cmpb_ff[15:8] : ptcc_pkg::RST_BYTE;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl0_ff <= ptcc_pkg::RST_BYTE;
      ctrl1_ff <= ptcc_pkg::RST_BYTE;
      tclr_ff  <= 2'h0;
    end
    else if (wr)
    begin
      if (addr == ptcc_pkg::ADDR_CTRL0)
        ctrl0_ff <= wd & 8'hf8;
      if (addr == ptcc_pkg::ADDR_CTRL1)
        ctrl1_ff <= wd;
      if (addr == ptcc_pkg::ADDR_CAPCLR && INST0)
        tclr_ff <= wd[ptcc_pkg::TCLR_LSB +: 2];
    end
  end

  // compare registers, capture writes win over software
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cmpa_ff <= '0;
      cmpp_ff <= '0;
      cmpb_ff <= 16'h0000;
    end
    else
    begin
      if (cap_a)
        cmpa_ff <= cnt_ff;
      else if (wr && addr == ptcc_pkg::ADDR_CMPA_LO)
        cmpa_ff[7:0] <= wd;
      else if (wr && addr == ptcc_pkg::ADDR_CMPA_HI)
        cmpa_ff[CNT_W-1:8] <= wd[HI_W-1:0];
      if (wr && addr == ptcc_pkg::ADDR_CMPP_LO)
        cmpp_ff[7:0] <= wd;
      else if (wr && addr == ptcc_pkg::ADDR_CMPP_HI)
        cmpp_ff[CNT_W-1:8] <= wd[HI_W-1:0];
      if (cap_b)
        cmpb_ff <= cnt_x;
      else if (wr && INST0 && addr == ptcc_pkg::ADDR_CMPB_LO)
        cmpb_ff[7:0] <= wd;
      else if (wr && INST0 && addr == ptcc_pkg::ADDR_CMPB_HI)
        cmpb_ff[15:8] <= wd;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_ff        <= '0;
      run_d_ff      <= 1'b0;
      vlf_ff        <= 1'b0;
      raw_ff        <= 1'b0;
      pulse_done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      run_d_ff <= run;
      raw_ff   <= nxt_raw;
      if (cap_a || cap_b)
        vlf_ff <= rise;
      if (run_up)
        pulse_done_ff <= 1'b0;
      else if (run && match_p)
        pulse_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cap_s1_ff <= 1'b0;
      cap_s2_ff <= 1'b0;
      cap_s3_ff <= 1'b0;
      pin_ff    <= 1'b0;
      pin_en_ff <= 1'b0;
      rdata_ff  <= ptcc_pkg::RST_BYTE;
    end
    else
    begin
      cap_s1_ff <= cap_src;
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
      pin_ff    <= nxt_pin;
      pin_en_ff <= out_used;
      rdata_ff  <= bus.rd ? nxt_rdata : ptcc_pkg::RST_BYTE;
    end
  end

  assign rdata        = rdata_ff;
  assign timer_out    = pin_ff;
  assign timer_out_en = pin_en_ff;

  // a_cnt_run_clear: run rising edge zeroes counter
  a_cnt_run_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    run_up |=> (cnt_ff == '0)) else $error("counter not cleared on run");
  // a_cnt_hold_off: count holds while stopped
  a_cnt_hold_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!run && !run_d_ff) ##1 !run |-> $stable(cnt_ff)) else $error("counter moved while off");
  // a_cap_latch_a: capture into A takes counter
  a_cap_latch_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cap_a |=> (cmpa_ff == $past(cnt_ff))) else $error("capture A wrong value");
  // a_cap_latch_b: capture into B on rising edge
  a_cap_latch_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cap_b |-> rise ##1 (cmpb_ff == 16'($past(cnt_ff)))) else $error("capture B wrong");
  // a_vlf_edge: flag reports edge
  a_vlf_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_a || cap_b) |=> (vlf_ff == $past(rise))) else $error("edge flag wrong");
  // a_out_restore: initial level after run edge
  a_out_restore: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (run_up && mode == ptcc_pkg::PTCC_CMP_OUT) |=> (pin_ff == ($past(oc) ^ $past(pol))))
    else $error("output not restored");
  // a_cmp_none: code 00 leaves the output
  a_cmp_none: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && pf == ptcc_pkg::PF_0 && !run_up) |=> $stable(raw_ff))
    else $error("output moved with no change code");
  // a_clr_on_a: compare A clear when selected
  a_clr_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (use_a && match_a && !run_up) |=> (cnt_ff == '0)) else $error("A match did not clear");
  // a_reg_hi_zero: capture clear top bits zero
  a_reg_hi_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bus.rd && addr == ptcc_pkg::ADDR_CAPCLR) |=> (rdata[7:3] == 5'h00)) else $error("top bits set");

  a_cap_rise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && !split && pf == ptcc_pkg::PF_0 && rise) |-> cap_a)
    else $error("rising capture missed");
  a_cap_fall_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && !split && pf == ptcc_pkg::PF_1 && fall) |-> cap_a)
    else $error("falling capture missed");
  a_cap_both_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && !split && pf == ptcc_pkg::PF_2 && (rise || fall)) |-> cap_a)
    else $error("dual edge capture missed");
  a_cap_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pf == ptcc_pkg::PF_3) |-> !(cap_a || cap_b))
    else $error("capture while disabled");
  a_split_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && split && pf == ptcc_pkg::PF_1 && fall) |-> (cap_a && !cap_b))
    else $error("split falling capture wrong");
  a_split_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && split && pf == ptcc_pkg::PF_0 && rise) |-> (cap_b && !cap_a))
    else $error("split rising capture wrong");
  a_split_dual: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && split && pf == ptcc_pkg::PF_2 && fall) |-> (cap_a && !cap_b))
    else $error("split dual capture wrong");

  a_cmp_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && match_a && !run_up && pf == ptcc_pkg::PF_1) |=> !raw_ff)
    else $error("match did not drive low");
  a_cmp_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && match_a && !run_up && pf == ptcc_pkg::PF_2) |=> raw_ff)
    else $error("match did not drive high");
  a_cmp_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && match_a && !run_up && pf == ptcc_pkg::PF_3) |=> (raw_ff != $past(raw_ff)))
    else $error("match did not toggle");
  a_cmp_same_lvl: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && match_a && !run_up && pf == ptcc_pkg::PF_1 && !oc && !raw_ff) |=> !raw_ff)
    else $error("same level request changed output");
  a_cmp_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT && !match_a && !run_up) |=> $stable(raw_ff))
    else $error("output moved without match");
  a_pin_invert: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> (pin_ff == (raw_ff ^ $past(pol))))
    else $error("pin inversion wrong");
  a_en_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_TIMER || mode == ptcc_pkg::PTCC_CAPTURE) |=> !timer_out_en)
    else $error("pin enabled in unused mode");
  a_en_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_CMP_OUT || mode == ptcc_pkg::PTCC_PWM) |=> timer_out_en)
    else $error("pin not enabled in output mode");

  a_pwm_inact: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_PWM && pf == ptcc_pkg::PF_0) |=> (raw_ff == !$past(oc)))
    else $error("forced inactive level wrong");
  a_pwm_act: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_PWM && pf == ptcc_pkg::PF_1) |=> (raw_ff == $past(oc)))
    else $error("forced active level wrong");
  a_pulse_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (run_up && mode == ptcc_pkg::PTCC_PWM && pf == ptcc_pkg::PF_3) |=> (raw_ff == $past(oc)))
    else $error("single pulse start level wrong");
  a_pulse_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == ptcc_pkg::PTCC_PWM && pf == ptcc_pkg::PF_3 && pulse_done_ff && !run_up) |=> (raw_ff == !$past(oc)))
    else $error("single pulse not ended");

  a_clr_on_p: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!use_a && match_p && !run_up) |=> (cnt_ff == '0))
    else $error("P match did not clear");
  a_clr_ovf: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!use_a && p_zero && at_max && !run_up) |=> (cnt_ff == '0))
    else $error("overflow did not clear");
  a_clr_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((mode == ptcc_pkg::PTCC_PWM || mode == ptcc_pkg::PTCC_CAPTURE) && run && !run_up && !match_p && !at_max
     && !edge_clr) |=> (cnt_ff == CNT_W'($past(cnt_ff) + 1'b1)))
    else $error("counter cleared by ignored select");
  a_edge_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cap_mode && INST0 && tclr_ff[0] && rise && !run_up) |=> (cnt_ff == '0))
    else $error("capture edge did not clear");
  a_cnt_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bus.rd && addr == ptcc_pkg::ADDR_CNT_LO) |=> (rdata == $past(cnt_x[7:0])))
    else $error("counter read wrong");
  a_src_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !caps |=> (cap_s1_ff == $past(capture_input_pin)))
    else $error("capture source not input pin");
  a_vlf_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(cap_a || cap_b) |=> $stable(vlf_ff))
    else $error("edge flag moved without capture");


  c_capture_a: cover property (@(posedge ref_clk) disable iff (sys_rst) cap_a);
  c_capture_b: cover property (@(posedge ref_clk) disable iff (sys_rst) cap_b);
  c_toggle:    cover property (@(posedge ref_clk) disable iff (sys_rst)
    match_a && pf == ptcc_pkg::PF_3 && mode == ptcc_pkg::PTCC_CMP_OUT);
  c_overflow:  cover property (@(posedge ref_clk) disable iff (sys_rst) p_zero && at_max);
endmodule

// *** verification/ptcc_pins_model.sv ***
// Pin-side model: capture sources and output pin watcher
`timescale 1ns/1ps
module ptcc_pins_model (
  input  wire logic ref_clk,
  output logic      capture_input_pin,
  output logic      external_clock_pin,
  output logic      filtered_data,
  input  wire logic timer_out,
  output int        out_edges
);
  logic last_out;
  int   n_edges = 0;
  initial
  begin
    capture_input_pin = 1'b0;
    external_clock_pin = 1'b0;
    filtered_data = 1'b0;
  end
  assign out_edges = n_edges;
  // Level moves just after an edge, then is held for the synchroniser
  task automatic drive(input int src, input logic lvl);
    @(posedge ref_clk);
    case (src)
      0: capture_input_pin <= lvl;
      1: external_clock_pin <= lvl;
      default: filtered_data <= lvl;
    endcase
  endtask
  // Counts changes of the output pin
  always @(posedge ref_clk)
  begin
    last_out <= timer_out;
    if (last_out !== timer_out)
      n_edges <= n_edges + 1;
  end
endmodule

// *** verification/periodic_timer_capture_compare_tb.sv ***
// Self-checking bench for the periodic timer capture/compare block
`timescale 1ns/1ps
module periodic_timer_capture_compare_tb;
  logic                ref_clk;
  logic                sys_rst;
  ptcc_pkg::ptcc_bus_t bus;
  logic [7:0]          rdata;
  logic                capture_input_pin;
  logic                external_clock_pin;
  logic                filtered_data;
  logic                filter_input_select;
  logic                timer_out;
  logic                timer_out_en;
  int                  out_edges;
  int                  n_fail = 0;
  int                  n_tests = 0;
  ptcc_timer #(.CNT_W(16), .INST0(1'b1)) ptcc_timer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
    .rdata(rdata), .capture_input_pin(capture_input_pin), .external_clock_pin(external_clock_pin),
    .filtered_data(filtered_data), .filter_input_select(filter_input_select), .timer_out(timer_out),
    .timer_out_en(timer_out_en));
  ptcc_pins_model ptcc_pins_model_inst (.ref_clk(ref_clk), .capture_input_pin(capture_input_pin),
    .external_clock_pin(external_clock_pin), .filtered_data(filtered_data), .timer_out(timer_out),
    .out_edges(out_edges));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    bus.wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick(1);
    bus.rd <= 1'b0;
    #1 d = rdata;
    tick(1);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 4'h1, d[15:8]);
  endtask
  // Pin function only changes while the timer is off
  task automatic restart(input logic [7:0] c1);
    wr(ptcc_pkg::ADDR_CTRL0, 8'h00);
    wr(ptcc_pkg::ADDR_CTRL1, c1);
    wr(ptcc_pkg::ADDR_CTRL0, ptcc_pkg::RUN_MASK);
  endtask
  task automatic t_regs;
    logic [7:0] v;
    logic [3:0] ra [7] = '{ptcc_pkg::ADDR_CMPA_LO, ptcc_pkg::ADDR_CMPA_HI, ptcc_pkg::ADDR_CMPB_LO,
                           ptcc_pkg::ADDR_CMPB_HI, ptcc_pkg::ADDR_CAPCLR, ptcc_pkg::ADDR_CNT_LO, 4'hb};
    logic [7:0] wx [7] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'hff, 8'hff, 8'hff};
    logic [7:0] rx [7] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h06, 8'h00, 8'h00};
    for (int a = 0; a < 12; a++)
    begin
      rd(4'(a), v);
      check("reset value", 16'(v), 16'h0000);
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(ra[i], wx[i]);
      rd(ra[i], v);
      check("read back", 16'(v), 16'(rx[i]));
    end
    wr(ptcc_pkg::ADDR_CAPCLR, 8'h00);
  endtask
  task automatic t_capture;
    logic [7:0]  v;
    logic [15:0] a;
    wr(ptcc_pkg::ADDR_CMPA_HI, 8'h00);
    for (int pf = 0; pf < 4; pf++)
    begin
      wr(ptcc_pkg::ADDR_CMPA_LO, 8'h00);
      restart({2'b01, 2'(pf), 4'h0});
      tick(20);
      rd(ptcc_pkg::ADDR_CNT_LO, v);
      ptcc_pins_model_inst.drive(0, 1'b1);
      tick(8);
      rd16(ptcc_pkg::ADDR_CMPA_LO, a);
      check("rise capture", 16'(a >= v + 3 && a <= v + 9), 16'(pf == 0 || pf == 2));
      rd(ptcc_pkg::ADDR_CNT_LO, v);
      ptcc_pins_model_inst.drive(0, 1'b0);
      tick(8);
      rd16(ptcc_pkg::ADDR_CMPA_LO, a);
      check("fall capture", 16'(a >= v + 3 && a <= v + 9), 16'(pf == 1 || pf == 2));
    end
  endtask
  task automatic t_source;
    logic [7:0] v;
    for (int s = 0; s < 3; s++)
    begin
      filter_input_select <= (s == 2);
      wr(ptcc_pkg::ADDR_CMPA_LO, 8'h00);
      restart({6'b010000, 1'(s != 0), 1'b0});
      tick(10);
      ptcc_pins_model_inst.drive((s + 1) % 3, 1'b1);
      tick(8);
      rd(ptcc_pkg::ADDR_CMPA_LO, v);
      check("other source", 16'(v), 16'h0000);
      ptcc_pins_model_inst.drive(s, 1'b1);
      tick(8);
      rd(ptcc_pkg::ADDR_CMPA_LO, v);
      check("chosen source", 16'(v != 8'h00), 16'h0001);
      for (int p = 0; p < 3; p++)
        ptcc_pins_model_inst.drive(p, 1'b0);
    end
    filter_input_select <= 1'b0;
  endtask
  task automatic t_dual;
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0]  f;
    wr(ptcc_pkg::ADDR_CMPA_LO, 8'h00);
    wr(ptcc_pkg::ADDR_CMPB_LO, 8'h00);
    wr(ptcc_pkg::ADDR_CMPB_HI, 8'h00);
    wr(ptcc_pkg::ADDR_CAPCLR, 8'h06);
    restart(8'h60);
    tick(60);
    ptcc_pins_model_inst.drive(0, 1'b1);
    tick(8);
    rd16(ptcc_pkg::ADDR_CMPB_LO, b);
    rd16(ptcc_pkg::ADDR_CMPA_LO, a);
    rd(ptcc_pkg::ADDR_CAPCLR, f);
    check("rise into b", 16'(b >= 16'd60 && b < 16'd90), 16'h0001);
    check("a untouched", a, 16'h0000);
    check("flag rising", 16'(f), 16'h0007);
    tick(10);
    ptcc_pins_model_inst.drive(0, 1'b0);
    tick(8);
    rd16(ptcc_pkg::ADDR_CMPA_LO, a);
    rd(ptcc_pkg::ADDR_CAPCLR, f);
    check("fall into a", 16'(a >= 16'd20 && a < 16'd50), 16'h0001);
    check("flag falling", 16'(f), 16'h0006);
    wr(ptcc_pkg::ADDR_CAPCLR, 8'h00);
  endtask
  task automatic t_output;
    int         e0;
    logic [9:0] row [8] = '{{8'h21, 2'b01}, {8'h11, 2'b00}, {8'h19, 2'b10}, {8'h09, 2'b11},
                           {8'h25, 2'b10}, {8'h89, 2'b00}, {8'h99, 2'b11}, {8'hb9, 2'b10}};
    wr(ptcc_pkg::ADDR_CMPA_LO, 8'd10);
    wr(ptcc_pkg::ADDR_CMPP_LO, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      restart(row[i][9:2]);
      tick(1);
      #1 check("before match", 16'(timer_out), 16'(row[i][1]));
      check("pin enable", 16'(timer_out_en), 16'h0001);
      tick(20);
      #1 check("after match", 16'(timer_out), 16'(row[i][0]));
      tick(1);
    end
    restart(8'h31);
    e0 = out_edges;
    tick(40);
    check("toggles", 16'(out_edges - e0 >= 3), 16'h0001);
    restart(8'hc1);
    tick(2);
    #1 check("timer mode pin", 16'(timer_out_en), 16'h0000);
    tick(1);
  endtask
  task automatic t_count;
    logic [7:0]  v;
    logic [7:0]  m;
    logic [23:0] row [3] = '{{8'hc0, 8'd0, 8'd15}, {8'hc1, 8'd10, 8'd10}, {8'h81, 8'd5, 8'd15}};
    wr(ptcc_pkg::ADDR_CMPP_LO, 8'd15);
    for (int i = 0; i < 3; i++)
    begin
      wr(ptcc_pkg::ADDR_CMPA_LO, row[i][15:8]);
      restart(row[i][23:16]);
      m = 8'h00;
      for (int k = 0; k < 16; k++)
      begin
        rd(ptcc_pkg::ADDR_CNT_LO, v);
        m = (v > m) ? v : m;
        tick(1);
      end
      check("count top", 16'(m >= row[i][7:0] - 8'd1 && m <= row[i][7:0]), 16'h0001);
    end
    wr(ptcc_pkg::ADDR_CTRL0, 8'h00);
    rd(ptcc_pkg::ADDR_CNT_LO, v);
    tick(5);
    rd(ptcc_pkg::ADDR_CNT_LO, m);
    check("count held", 16'(m), 16'(v));
  endtask
  initial
  begin
    bus = '0;
    sys_rst = 1'b1;
    filter_input_select = 1'b0;
    tick(20);
    sys_rst <= 1'b0;
    tick(1);
    t_regs;
    t_capture;
    t_source;
    t_dual;
    t_output;
    t_count;
    final_report;
  end
  initial
  begin
    tick(60000);
    n_fail++;
    final_report;
  end
endmodule
